// ===== hdl/sif_consts.svh
/*
 * Constants for the sequence input function logic: register indexes,
 * input function codes, mode values and reset values.
 * Assumes inclusion by bare name from design files.
 */
`ifndef SIF_CONSTS_SVH
`define SIF_CONSTS_SVH
// ****************************************
// register indexes (word index on the register port)
// ****************************************
`define SIF_REG_TCODE0 5'h00
`define SIF_REG_MODE 5'h10
`define SIF_REG_GCAUSE 5'h11
`define SIF_REG_PRESET 5'h12
`define SIF_REG_GNUM0 5'h14
`define SIF_REG_GDEN 5'h18
`define SIF_REG_RAT1 5'h19
`define SIF_REG_RAT2 5'h1A
`define SIF_REG_TL0 5'h1B
`define SIF_REG_TL1 5'h1C
`define SIF_REG_STAT 5'h1F
// ****************************************
// input function codes
// ****************************************
`define SIF_FN_PRESET 16
`define SIF_FN_GAINSW 17
`define SIF_FN_SPDCOM 18
`define SIF_FN_TL0 19
`define SIF_FN_TL1 20
`define SIF_FN_TRQCOM 21
`define SIF_FN_IMMCONT 22
`define SIF_FN_IMMCHG 23
`define SIF_FN_GEAR0 24
`define SIF_FN_GEAR1 25
`define SIF_FN_PINH 26
`define SIF_FN_RAT1 27
`define SIF_FN_RAT2 28
`define SIF_FN_PROP 29
`define SIF_FN_PAUSE 31
`define SIF_FN_CANCEL 32
`define SIF_FN_TEACH 35
`define SIF_FN_POSCTL 37
`define SIF_FN_STEP_A 51
`define SIF_FN_STEP_B 52
`define SIF_FN_STEP_C 53
`define SIF_FN_ADDR0 60
`define SIF_FN_PULSPD 70
// ****************************************
// modes, limits, reset values
// ****************************************
`define SIF_MODE_EXT 3'h6
`define SIF_MODE_POSN 3'h7
`define SIF_GCAUSE_EXT 3'h3
`define SIF_TL_MAX 9'h12C
`define SIF_GNUM_RST 16'h0001
`define SIF_GDEN_RST 16'h0001
`define SIF_RAT_RST 16'h0001
`define SIF_TL_RST 9'h12C
`endif

// ===== hdl/sif_input_func.sv
/*
 * Sequence input function logic: synchronises the input terminals, maps
 * each to its assigned function code and turns levels and rising edges
 * into drive actions and command selections.
 * Assumes the motion generator, gain blocks and position table sit
 * outside and consume the pulses and levels driven here.
 */
// Design decisions made here: the register offsets and the strobed register port.
`default_nettype none
`include "sif_consts.svh"

// Overview of operation
// [RULE1] preset loads command, feedback minus deviation
// [RULE2] rising edge means inactive to active
// [RULE3] unassigned functions read as inactive
// [RULE4] gain cause 3: switch picks gain set
// [RULE5] speed from comm value when selected
// [RULE6] torque limit 0..300 percent, all modes
// [RULE7] torque from comm value when selected
// [RULE8] immediate continuation in positioning mode only
// [RULE9] immediate change edge while not in-position
// [RULE10] two selects index four gear numerators
// [RULE11] pulse inhibit ignores command pulses
// [RULE12] pulse operation needs servo, position, ratio
// [RULE13] encoder pulses from gear and ratio
// [RULE14] proportional input selects proportional control
// [RULE15] pause decelerates, holds, then resumes
// [RULE16] pause ignores pulse and manual motion
// [RULE17] cancel stops auto, homing, interrupt motion
// [RULE18] teaching writes command position to table
// [RULE19] teaching ignores forced stop and servo-on
// [RULE20] preset marks homing completed
// [RULE21] mode 6 extension, 7 positioning
// [RULE22] terminals synchronised, edges from samples
module sif_input_func #(
  parameter int NT = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output wire logic [31:0] reg_rdata,
  // input terminals from pins
  input wire logic [NT-1:0] input_terminal,
  // drive state from the rest of the drive
  input wire sif_pkg::sif_ctrl_t ctrl_state,
  input wire logic servo_on,
  input wire logic in_position,
  input wire logic imm_active,
  input wire logic motion_pausable,
  input wire logic motion_cancellable,
  input wire logic signed [31:0] deviation,
  input wire logic signed [31:0] cmd_pos_now,
  input wire logic [15:0] pulse_cnt,
  // position preset
  output wire logic preset_load,
  output wire logic signed [31:0] preset_cmd_pos,
  output wire logic signed [31:0] preset_fb_pos,
  output wire logic homing_done,
  // command selections
  output wire logic gain_set2,
  output wire logic spd_from_comm,
  output wire logic trq_from_comm,
  output wire logic torque_limit_on,
  output wire logic [8:0] torque_limit_pct,
  output wire logic prop_ctrl,
  // immediate value operation
  output wire logic imm_continue,
  output wire logic imm_change,
  // pulse train path
  output wire logic [15:0] gear_num,
  output wire logic pulse_accept,
  output wire logic pulse_op_en,
  output wire logic [47:0] enc_pulses,
  // pause, cancel, teaching
  output wire logic pause_decel,
  output wire logic pause_hold,
  output wire logic pos_cancel,
  output wire logic teach_wr,
  output wire logic [3:0] teach_addr,
  output wire logic signed [31:0] teach_data
);

  if (NT < 1 || NT > 16) begin : g_bad_nt
    $error("NT must lie between 1 and 16");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NT-1:0] s1;
    logic [NT-1:0] s2;
    logic [127:0] fprev;
    logic [NT-1:0][7:0] tcode;
    logic [2:0] mode;
    logic [2:0] gcause;
    logic signed [31:0] preset;
    logic [3:0][15:0] gnum;
    logic [15:0] gden;
    logic [15:0] rat1;
    logic [15:0] rat2;
    logic [8:0] tl0;
    logic [8:0] tl1;
    logic [31:0] rdata;
    logic pload;
    logic signed [31:0] cpos;
    logic signed [31:0] fpos;
    logic homed;
    logic gain2;
    logic spdc;
    logic trqc;
    logic tlon;
    logic [8:0] tlpct;
    logic prop;
    logic cont;
    logic chg;
    logic [15:0] gsel;
    logic pacc;
    logic pen;
    logic [47:0] enc;
    logic pdec;
    logic hold;
    logic cancel;
    logic teach;
    logic [3:0] taddr;
    logic signed [31:0] tdata;
  } sif_state_t;

  sif_state_t st_ff;
  sif_state_t nxt_st;
  logic [NT-1:0][127:0] term_hot;
  logic [127:0] fn;
  logic [127:0] rise;

  // ****************************************
  // terminal to function mapping
  // ****************************************
  // one-hot per terminal; a code nobody holds never sets its bit [RULE3]
  for (genvar t = 0; t < NT; t++) begin : g_term
    assign term_hot[t] = st_ff.s2[t] ? (128'h1 << st_ff.tcode[t][6:0]) : 128'h0;
  end

  // or of all terminals, edges from consecutive samples [RULE2] [RULE22]
  always_comb
  begin
    fn = 128'h0;
    for (int t = 0; t < NT; t++)
    begin
      fn = fn | term_hot[t];
    end
    rise = fn & ~st_ff.fprev;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [3:0] mode_ok;
    logic pos_ok;
    logic [15:0] ratio;
    logic [31:0] scaled;
    mode_ok = 4'h0;
    pos_ok = 1'b0;
    ratio = 16'h0;
    scaled = 32'h0;
    nxt_st = st_ff;
    // two flops before any logic reads a pin [RULE22]
    nxt_st.s1 = input_terminal;
    nxt_st.s2 = st_ff.s1;
    nxt_st.fprev = fn;

    // register writes; torque limits clamp to the maximum
    if (reg_wr)
    begin
      if (reg_addr < 5'(NT))
        nxt_st.tcode[reg_addr[3:0]] = reg_wdata[7:0];
      case (reg_addr)
        `SIF_REG_MODE: nxt_st.mode = reg_wdata[2:0];
        `SIF_REG_GCAUSE: nxt_st.gcause = reg_wdata[2:0];
        `SIF_REG_PRESET: nxt_st.preset = reg_wdata;
        `SIF_REG_GDEN: nxt_st.gden = reg_wdata[15:0];
        `SIF_REG_RAT1: nxt_st.rat1 = reg_wdata[15:0];
        `SIF_REG_RAT2: nxt_st.rat2 = reg_wdata[15:0];
        `SIF_REG_TL0: nxt_st.tl0 = (reg_wdata > 32'(`SIF_TL_MAX)) ? `SIF_TL_MAX : reg_wdata[8:0];
        `SIF_REG_TL1: nxt_st.tl1 = (reg_wdata > 32'(`SIF_TL_MAX)) ? `SIF_TL_MAX : reg_wdata[8:0];
        default: ;
      endcase
      if (reg_addr[4:2] == 3'(`SIF_REG_GNUM0 >> 2))
        nxt_st.gnum[reg_addr[1:0]] = reg_wdata[15:0];
    end

    // register reads, answer stands one cycle; unmapped reads zero
    nxt_st.rdata = 32'h0;
    if (reg_rd)
    begin
      if (reg_addr < 5'(NT))
        nxt_st.rdata = {24'h0, st_ff.tcode[reg_addr[3:0]]};
      case (reg_addr)
        `SIF_REG_MODE: nxt_st.rdata = {29'h0, st_ff.mode};
        `SIF_REG_GCAUSE: nxt_st.rdata = {29'h0, st_ff.gcause};
        `SIF_REG_PRESET: nxt_st.rdata = st_ff.preset;
        `SIF_REG_GDEN: nxt_st.rdata = {16'h0, st_ff.gden};
        `SIF_REG_RAT1: nxt_st.rdata = {16'h0, st_ff.rat1};
        `SIF_REG_RAT2: nxt_st.rdata = {16'h0, st_ff.rat2};
        `SIF_REG_TL0: nxt_st.rdata = {23'h0, st_ff.tl0};
        `SIF_REG_TL1: nxt_st.rdata = {23'h0, st_ff.tl1};
        `SIF_REG_STAT: nxt_st.rdata = {8'h0, 16'(st_ff.s2), st_ff.homed, st_ff.hold,
                                       st_ff.prop, st_ff.pen, st_ff.pacc, st_ff.tlon,
                                       st_ff.gain2, st_ff.spdc};
        default: ;
      endcase
      if (reg_addr[4:2] == 3'(`SIF_REG_GNUM0 >> 2))
        nxt_st.rdata = {16'h0, st_ff.gnum[reg_addr[1:0]]};
    end

    // mode qualifiers: 6 extension, 7 positioning [RULE21]
    mode_ok[2] = (st_ff.mode == `SIF_MODE_EXT) || (st_ff.mode == `SIF_MODE_POSN);
    mode_ok[3] = (st_ff.mode == `SIF_MODE_POSN);

    // position preset; the host presets only at standstill [RULE1] [RULE20]
    nxt_st.pload = rise[`SIF_FN_PRESET];
    if (rise[`SIF_FN_PRESET])
    begin
      nxt_st.cpos = st_ff.preset;
      nxt_st.fpos = st_ff.preset - deviation;
      nxt_st.homed = 1'b1;
    end

    // gain set, speed and torque sources, torque limit, p-control
    nxt_st.gain2 = (st_ff.gcause == `SIF_GCAUSE_EXT) && fn[`SIF_FN_GAINSW]; // [RULE4]
    nxt_st.spdc = (ctrl_state != sif_pkg::SIF_TRQ) && fn[`SIF_FN_SPDCOM]
                  && !fn[`SIF_FN_STEP_A] && !fn[`SIF_FN_STEP_B]
                  && !fn[`SIF_FN_STEP_C] && !fn[`SIF_FN_PULSPD]; // [RULE5]
    nxt_st.trqc = (ctrl_state == sif_pkg::SIF_TRQ) && fn[`SIF_FN_TRQCOM]; // [RULE7]
    nxt_st.tlon = fn[`SIF_FN_TL0] | fn[`SIF_FN_TL1]; // [RULE6]
    nxt_st.tlpct = fn[`SIF_FN_TL1] ? st_ff.tl1 : st_ff.tl0; // [RULE6]
    nxt_st.prop = fn[`SIF_FN_PROP]; // [RULE14]

    // immediate value operation, positioning mode only
    nxt_st.cont = mode_ok[3] && imm_active && rise[`SIF_FN_IMMCONT]; // [RULE8]
    nxt_st.chg = mode_ok[3] && !in_position && rise[`SIF_FN_IMMCHG]; // [RULE9]

    // gear numerator and pulse path; a zero denominator yields no pulses
    nxt_st.gsel = st_ff.gnum[{fn[`SIF_FN_GEAR1], fn[`SIF_FN_GEAR0]}]; // [RULE10]
    nxt_st.pacc = servo_on && (ctrl_state == sif_pkg::SIF_POS) && !fn[`SIF_FN_PINH]; // [RULE11]
    pos_ok = (st_ff.mode == `SIF_MODE_EXT) ? fn[`SIF_FN_POSCTL] : (ctrl_state == sif_pkg::SIF_POS);
    nxt_st.pen = mode_ok[2] && servo_on && pos_ok
                 && (fn[`SIF_FN_RAT1] | fn[`SIF_FN_RAT2]); // [RULE12]
    ratio = fn[`SIF_FN_RAT1] ? st_ff.rat1 : st_ff.rat2; // [RULE12]
    // divide before the ratio multiply, as the formula orders it
    if (st_ff.gden != 16'h0)
      scaled = (32'(pulse_cnt) * 32'(st_ff.gsel)) / 32'(st_ff.gden); // [RULE13]
    nxt_st.enc = (st_ff.pen && st_ff.pacc) ? 48'(scaled) * 48'(ratio) : 48'h0; // [RULE13]

    // pause acts on pausable motion only, cancel on cancellable motion only [RULE15] [RULE16] [RULE17]
    nxt_st.pdec = rise[`SIF_FN_PAUSE] && motion_pausable;
    nxt_st.hold = fn[`SIF_FN_PAUSE] && motion_pausable;
    nxt_st.cancel = rise[`SIF_FN_CANCEL] && motion_cancellable;

    // teaching, not gated by servo-on or forced stop [RULE18] [RULE19]
    nxt_st.teach = mode_ok[3] && rise[`SIF_FN_TEACH];
    if (mode_ok[3] && rise[`SIF_FN_TEACH])
    begin
      nxt_st.taddr = fn[`SIF_FN_ADDR0 +: 4];
      nxt_st.tdata = cmd_pos_now;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.gnum <= {4{`SIF_GNUM_RST}};
      st_ff.gden <= `SIF_GDEN_RST;
      st_ff.rat1 <= `SIF_RAT_RST;
      st_ff.rat2 <= `SIF_RAT_RST;
      st_ff.tl0 <= `SIF_TL_RST;
      st_ff.tl1 <= `SIF_TL_RST;
      st_ff.tlpct <= `SIF_TL_RST;
      st_ff.gsel <= `SIF_GNUM_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state flops
  assign reg_rdata = st_ff.rdata;
  assign preset_load = st_ff.pload;
  assign preset_cmd_pos = st_ff.cpos;
  assign preset_fb_pos = st_ff.fpos;
  assign homing_done = st_ff.homed;
  assign gain_set2 = st_ff.gain2;
  assign spd_from_comm = st_ff.spdc;
  assign trq_from_comm = st_ff.trqc;
  assign torque_limit_on = st_ff.tlon;
  assign torque_limit_pct = st_ff.tlpct;
  assign prop_ctrl = st_ff.prop;
  assign imm_continue = st_ff.cont;
  assign imm_change = st_ff.chg;
  assign gear_num = st_ff.gsel;
  assign pulse_accept = st_ff.pacc;
  assign pulse_op_en = st_ff.pen;
  assign enc_pulses = st_ff.enc;
  assign pause_decel = st_ff.pdec;
  assign pause_hold = st_ff.hold;
  assign pos_cancel = st_ff.cancel;
  assign teach_wr = st_ff.teach;
  assign teach_addr = st_ff.taddr;
  assign teach_data = st_ff.tdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_preset_load: assert property ( // [RULE1]
    rise[`SIF_FN_PRESET] |=> preset_load && preset_cmd_pos == $past(st_ff.preset)
      && preset_fb_pos == $past(st_ff.preset - deviation))
    else $error("preset did not load positions");
  chk_preset_homed: assert property ( // [RULE20]
    preset_load |-> homing_done ##1 homing_done)
    else $error("preset did not mark homing done");
  chk_gain_select: assert property ( // [RULE4]
    ##1 gain_set2 == $past(st_ff.gcause == `SIF_GCAUSE_EXT && fn[`SIF_FN_GAINSW]))
    else $error("gain set does not follow switch");
  chk_gear_index: assert property ( // [RULE10]
    ##1 gear_num == $past(st_ff.gnum[{fn[`SIF_FN_GEAR1], fn[`SIF_FN_GEAR0]}]))
    else $error("gear numerator index wrong");
  chk_tl_range: assert property ( // [RULE6]
    torque_limit_pct <= `SIF_TL_MAX)
    else $error("torque limit above maximum");
  chk_pulse_inhibit: assert property ( // [RULE11]
    fn[`SIF_FN_PINH] |=> !pulse_accept ##1 enc_pulses == 48'h0)
    else $error("pulses taken while inhibited");
  chk_change_gate: assert property ( // [RULE9]
    imm_change |-> $past(!in_position && st_ff.mode == `SIF_MODE_POSN))
    else $error("immediate change outside its window");
  chk_teach_write: assert property ( // [RULE18]
    teach_wr |-> $past(rise[`SIF_FN_TEACH]) && teach_data == $past(cmd_pos_now))
    else $error("teaching write without edge");
  chk_pause_gate: assert property ( // [RULE16]
    (pause_hold || pause_decel) |-> $past(motion_pausable))
    else $error("pause acted on non-pausable motion");

endmodule : sif_input_func
`default_nettype wire

// ===== hdl/sif_pkg.sv
/*
 * Types for the sequence input function logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package sif_pkg;
  // present control state reported by the mode switching logic
  typedef enum logic [1:0] {
    SIF_POS = 2'b00,
    SIF_SPD = 2'b01,
    SIF_TRQ = 2'b10
  } sif_ctrl_t;
endpackage : sif_pkg
`default_nettype wire

// ===== test/sif_host_model.sv
/*
 * Far side model: the host controller or switches driving the input terminals.
 * Assumes the bench asks for pin levels on the system clock.
 */
`default_nettype none
module sif_host_model #(
  parameter int NT = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // requested levels and pins
  input wire logic [NT-1:0] lvl_req,
  output logic [NT-1:0] input_terminal
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin drive
  // ****************************************
  // pins move just after an edge; switches are always driven, so no
  // released level exists on these lines
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_terminal <= '0;
    end
    else
    begin
      input_terminal <= lvl_req;  // preset asked only with motion idle
    end
  end
endmodule : sif_host_model
`default_nettype wire

// ===== test/sif_input_func_tb_top.sv
/*
 * Self-checking bench for the sequence input function logic.
 * Assumes the design files and the constants header are compiled first.
 */
`default_nettype none
`include "sif_consts.svh"
`define CHK(nm, e, g) total_checks++; \
  if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end
module sif_input_func_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] pin_req = '0;
  sif_pkg::sif_ctrl_t ctrl_state = sif_pkg::SIF_POS;
  logic servo_on = 1'b1;
  logic in_position = 1'b1;
  logic signed [31:0] deviation = 32'sh10;
  logic signed [31:0] cmd_pos_now = 32'sh1234;
  logic imm_active = 1'b0;
  logic motion_pausable = 1'b0;
  logic motion_cancellable = 1'b0;
  logic [15:0] pulse_cnt = '0;
  wire logic [31:0] reg_rdata;
  wire logic [5:0] input_terminal;
  wire logic preset_load, homing_done, gain_set2, spd_from_comm, trq_from_comm;
  wire logic torque_limit_on, prop_ctrl, teach_wr, pos_cancel;
  wire logic imm_continue, imm_change, pulse_accept, pulse_op_en, pause_decel, pause_hold;
  wire logic [47:0] enc_pulses;
  wire logic signed [31:0] preset_cmd_pos, preset_fb_pos, teach_data;
  wire logic [8:0] torque_limit_pct;
  wire logic [15:0] gear_num;
  wire logic [3:0] teach_addr;
  wire logic [3:0] lvl_out = {prop_ctrl, trq_from_comm, spd_from_comm, gain_set2};
  int bad_count = 0;
  int total_checks = 0;
  // logic counters, so an unknown pulse spoils the count instead of hiding
  logic [15:0] n_pre = '0;
  logic [15:0] n_teach = '0;
  logic [15:0] n_pdec = '0;
  logic [15:0] n_cancel = '0;
  logic [15:0] n_cont = '0;
  logic [15:0] n_chg = '0;
  int cyc = 0;
  logic [31:0] d;
  // ****************************************
  // clock, instances, monitors
  // ****************************************
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  sif_host_model #(.NT(6)) i_sif_host_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .lvl_req(pin_req), .input_terminal(input_terminal));
  sif_input_func #(.NT(6)) i_sif_input_func (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .input_terminal(input_terminal), .ctrl_state(ctrl_state),
    .servo_on(servo_on), .in_position(in_position), .imm_active(imm_active),
    .motion_pausable(motion_pausable), .motion_cancellable(motion_cancellable),
    .deviation(deviation), .cmd_pos_now(cmd_pos_now), .pulse_cnt(pulse_cnt),
    .preset_load(preset_load),
    .preset_cmd_pos(preset_cmd_pos), .preset_fb_pos(preset_fb_pos),
    .homing_done(homing_done), .gain_set2(gain_set2), .spd_from_comm(spd_from_comm),
    .trq_from_comm(trq_from_comm), .torque_limit_on(torque_limit_on),
    .torque_limit_pct(torque_limit_pct), .prop_ctrl(prop_ctrl), .imm_continue(imm_continue),
    .imm_change(imm_change), .gear_num(gear_num), .pulse_accept(pulse_accept),
    .pulse_op_en(pulse_op_en), .enc_pulses(enc_pulses), .pause_decel(pause_decel),
    .pause_hold(pause_hold), .pos_cancel(pos_cancel), .teach_wr(teach_wr),
    .teach_addr(teach_addr), .teach_data(teach_data));
  // pulse counts let a check ignore the exact landing cycle
  always @(posedge clk_sys)
  begin
    n_pre <= n_pre + 16'(preset_load);
    n_teach <= n_teach + 16'(teach_wr);
    n_pdec <= n_pdec + 16'(pause_decel);
    n_cancel <= n_cancel + 16'(pos_cancel);
    n_cont <= n_cont + 16'(imm_continue);
    n_chg <= n_chg + 16'(imm_change);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // ****************************************
  // helper tasks
  // ****************************************
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_n
  task automatic wreg(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rreg
  // pins take the new level one clock later through the host model; the task waits six cycles in all, counting that clock, for the outputs to settle
  task automatic drive(input logic [5:0] v);
    @(posedge clk_sys);
    pin_req <= v;
    wait_n(6);
  endtask : drive
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rreg(`SIF_REG_TL0, d);
    `CHK("tl0 reset", 32'h0000012C, d)
    `CHK("tl pct reset", 9'h12C, torque_limit_pct)
    rreg(`SIF_REG_GNUM0, d);
    `CHK("gnum0 reset", 32'h00000001, d)
    rreg(5'h13, d);
    `CHK("unmapped read", 32'h00000000, d)
    $display("test reset done");
  endtask : t_reset
  task automatic t_preset();
    wreg(`SIF_REG_PRESET, 32'h00000100);
    wreg(`SIF_REG_TCODE0, 32'(`SIF_FN_PRESET));
    drive(6'h01);
    drive(6'h01);
    `CHK("preset pulses", 1, n_pre)
    `CHK("preset cmd", 32'sh100, preset_cmd_pos)
    `CHK("preset fb", 32'shF0, preset_fb_pos)
    rreg(`SIF_REG_STAT, d);
    `CHK("homing done", 1'b1, d[7])
    drive(6'h00);
    wreg(`SIF_REG_TCODE0, 32'h0);
    $display("test preset done");
  endtask : t_preset
  task automatic t_levels();
    logic [7:0] codes [4] = '{8'd17, 8'd18, 8'd21, 8'd29};
    wreg(`SIF_REG_GCAUSE, 32'(`SIF_GCAUSE_EXT));
    drive(6'h3F);
    `CHK("unassigned", 4'h0, lvl_out)
    drive(6'h00);
    for (int i = 0; i < 4; i++)
    begin
      wreg(5'(i), {24'h0, codes[i]});
      ctrl_state <= (i == 2) ? sif_pkg::SIF_TRQ : sif_pkg::SIF_POS;
      drive(6'(1 << i));
      `CHK("level fn", 4'(1 << i), lvl_out)
      drive(6'h00);
      wreg(5'(i), 32'h0);
    end
    $display("test levels done");
  endtask : t_levels
  task automatic t_gear_tl();
    wreg(5'h00, 32'(`SIF_FN_GEAR0));
    wreg(5'h01, 32'(`SIF_FN_GEAR1));
    for (int i = 0; i < 4; i++)
    begin
      wreg(5'(`SIF_REG_GNUM0 + i), 32'(5 + i));
    end
    for (int i = 0; i < 4; i++)
    begin
      drive(6'(i));
      `CHK("gear num", 16'(5 + i), gear_num)
    end
    wreg(5'h02, 32'(`SIF_FN_TL0));
    wreg(`SIF_REG_TL0, 32'd400);
    rreg(`SIF_REG_TL0, d);
    `CHK("tl clamp", 32'h0000012C, d)
    wreg(`SIF_REG_TL0, 32'd50);
    drive(6'h04);
    `CHK("tl active", {1'b1, 9'd50}, {torque_limit_on, torque_limit_pct})
    drive(6'h00);
    $display("test gear and limit done");
  endtask : t_gear_tl
  task automatic t_teach();
    for (int i = 0; i < 4; i++)
    begin
      wreg(5'(i), 32'(`SIF_FN_ADDR0 + i));
    end
    wreg(5'h04, 32'(`SIF_FN_TEACH));
    wreg(`SIF_REG_MODE, 32'(`SIF_MODE_POSN));
    servo_on <= 1'b0;
    drive(6'h0A);
    drive(6'h1A);
    `CHK("teach pulses", 1, n_teach)
    `CHK("teach addr", 4'hA, teach_addr)
    `CHK("teach data", 32'sh1234, teach_data)
    drive(6'h0A);
    wreg(`SIF_REG_MODE, 32'(`SIF_MODE_EXT));
    drive(6'h1A);
    `CHK("teach mode 6", 1, n_teach)
    $display("test teach done");
  endtask : t_teach
  task automatic t_motion();
    drive(6'h00);
    wreg(5'h00, 32'(`SIF_FN_PAUSE));
    wreg(5'h01, 32'(`SIF_FN_CANCEL));
    wreg(5'h02, 32'(`SIF_FN_IMMCONT));
    wreg(5'h03, 32'(`SIF_FN_IMMCHG));
    wreg(5'h04, 32'h0);
    wreg(`SIF_REG_MODE, 32'(`SIF_MODE_POSN));
    // nothing pausable or cancellable, no immediate run, still in position
    drive(6'h0F);
    `CHK("pause gated", 16'h0, n_pdec)
    `CHK("cancel gated", 16'h0, n_cancel)
    `CHK("cont gated", 16'h0, n_cont)
    `CHK("change in position", 16'h0, n_chg)
    drive(6'h00);
    @(posedge clk_sys);
    motion_pausable <= 1'b1;
    motion_cancellable <= 1'b1;
    imm_active <= 1'b1;
    in_position <= 1'b0;
    drive(6'h0F);
    `CHK("pause decel", 16'h1, n_pdec)
    `CHK("pause hold", 1'b1, pause_hold)
    `CHK("cancel", 16'h1, n_cancel)
    `CHK("cont", 16'h1, n_cont)
    `CHK("change", 16'h1, n_chg)
    drive(6'h00);
    `CHK("pause release", 1'b0, pause_hold)
    wreg(`SIF_REG_MODE, 32'(`SIF_MODE_EXT));
    drive(6'h0C);
    `CHK("cont mode 6", 16'h1, n_cont)
    `CHK("change mode 6", 16'h1, n_chg)
    drive(6'h00);
    $display("test motion done");
  endtask : t_motion
  task automatic t_pulse();
    wreg(5'h00, 32'(`SIF_FN_RAT1));
    wreg(5'h01, 32'(`SIF_FN_RAT2));
    wreg(5'h02, 32'(`SIF_FN_PINH));
    wreg(5'h03, 32'(`SIF_FN_POSCTL));
    wreg(`SIF_REG_GDEN, 32'h2);
    wreg(`SIF_REG_RAT1, 32'h3);
    wreg(`SIF_REG_RAT2, 32'h4);
    wreg(`SIF_REG_MODE, 32'(`SIF_MODE_POSN));
    servo_on <= 1'b1;
    pulse_cnt <= 16'h0004;
    // numerator 0 still holds 5: 4 * 5 / 2 = 10 before the ratio
    drive(6'h01);
    `CHK("pulse op ratio 1", 2'b11, {pulse_op_en, pulse_accept})
    `CHK("enc ratio 1", 48'h1E, enc_pulses)
    drive(6'h02);
    `CHK("enc ratio 2", 48'h28, enc_pulses)
    drive(6'h06);
    `CHK("inhibit accept", 1'b0, pulse_accept)
    `CHK("inhibit enc", 48'h0, enc_pulses)
    drive(6'h00);
    `CHK("no ratio input", 1'b0, pulse_op_en)
    wreg(`SIF_REG_MODE, 32'(`SIF_MODE_EXT));
    drive(6'h01);
    `CHK("mode 6 no posctl", 1'b0, pulse_op_en)
    drive(6'h09);
    `CHK("mode 6 posctl", 1'b1, pulse_op_en)
    drive(6'h00);
    $display("test pulse done");
  endtask : t_pulse
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_preset();
    t_levels();
    t_gear_tl();
    t_teach();
    t_motion();
    t_pulse();
    give_verdict();
  end
endmodule : sif_input_func_tb_top
`default_nettype wire
